// ---- design/pcl_host.sv ----
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pcl_host
   import pcl_pkg::*;
#(
   parameter int HALF = CCLK_HALF
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   pcl_if.host                    link
);

   typedef struct packed {
      pcl_host_st_t      st;
      logic [7:0]        div;
      logic              cclk;
      logic [2:0]        beat;
      logic [1:0]        falls;
      logic [7:0]        cnt;
      logic              w16;
      logic              dec;
      logic              sec;
      logic [WORD_W-1:0] word;
      logic              full;
      logic              doe;
      logic              req_n;
      logic              pready;
      logic              slverr;
      logic [31:0]       prdata;
      logic [N_EV-1:0]   istat;
      logic [N_EV-1:0]   mask;
      logic              irq;
   } pcl_host_t;

   pcl_host_t       r_reg, r_next;
   logic [2:0]      sync_q;
   logic [2:0]      ratio;
   logic            acc;
   logic [N_EV-1:0] ev;

   // ----------------------------------------------------------------
   // Status line synchronisers
   // ----------------------------------------------------------------
   pcl_sync #(.W(3), .INIT(3'h5)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({link.device_ready_n, link.load_complete, link.init_done}),
      .q    (sync_q)
   );

   assign ratio = pcl_ratio(r_reg.w16, r_reg.dec, r_reg.sec);
   assign acc   = psel & penable & ~r_reg.pready;

   // ----------------------------------------------------------------
   // Register access and load sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      r_next        = r_reg;
      r_next.pready = 1'b0;
      r_next.slverr = 1'b0;
      ev            = '0;
      if (acc)
      begin
         r_next.prdata = '0;
         r_next.pready = 1'b1;
         if (paddr == A_CTRL)
         begin
            r_next.prdata = {28'h0000000, r_reg.sec, r_reg.dec, r_reg.w16, 1'b0};
            if (pwrite)
            begin
               r_next.w16 = pwdata[C_WIDE];
               r_next.dec = pwdata[C_DECOMP];
               r_next.sec = pwdata[C_SECURE];
               if (pwdata[C_START] && r_reg.st == H_IDLE)
               begin
                  r_next.st    = H_REQ;
                  r_next.req_n = 1'b0;
                  r_next.cnt   = '0;
               end
            end
         end
         else if (paddr == A_STATUS)
            r_next.prdata = {24'h000000, sync_q, r_reg.full, 1'b0, r_reg.st};
         else if (paddr == A_DATA)
         begin
            // Write stalls while a word is pending once a load is under way;
            // otherwise a second word written before the load starts replaces the first
            if (pwrite && r_reg.full && r_reg.st != H_IDLE)
               r_next.pready = 1'b0;
            else if (pwrite)
            begin
               r_next.word = r_reg.w16 ? pwdata[WORD_W-1:0] : {8'h00, pwdata[7:0]};
               r_next.full = 1'b1;
            end
         end
         else if (paddr == A_ISTAT)
         begin
            r_next.prdata = {29'h00000000, r_reg.istat};
            if (!pwrite)
               r_next.istat = '0;
         end
         else if (paddr == A_IMASK)
         begin
            r_next.prdata = {29'h00000000, r_reg.mask};
            if (pwrite)
               r_next.mask = pwdata[N_EV-1:0];
         end
         else
            r_next.slverr = 1'b1;
      end
      case (r_reg.st)
         H_REQ:
         begin
            r_next.cnt = r_reg.cnt + 8'h01;
            if (r_reg.cnt == 8'(REQ_LOW_CYC - 1))
            begin
               r_next.st    = H_WAIT;
               r_next.req_n = 1'b1;
            end
         end
         H_WAIT:
         begin
            // No data until the device lets its ready line go
            if (sync_q[2])
            begin
               r_next.st   = H_LOAD;
               r_next.doe  = 1'b1;
               r_next.beat = '0;
               r_next.div  = '0;
               ev[E_READY] = 1'b1;
            end
         end
         H_LOAD, H_TAIL:
         begin
            r_next.div = r_reg.div + 8'h01;
            if (r_reg.cclk && r_reg.div == 8'(HALF - 1))
            begin
               // Falling edge ends a clock cycle of the current word
               r_next.cclk = 1'b0;
               r_next.div  = '0;
               r_next.falls = r_reg.falls + 2'h1;
               if (r_reg.st == H_TAIL && r_reg.falls == 2'(TAIL_FALLS - 1))
               begin
                  r_next.st  = H_IDLE;
                  r_next.doe = 1'b0;
                  ev[E_DONE] = 1'b1;
               end
               if (r_reg.beat == ratio - 3'h1)
               begin
                  r_next.beat = '0;
                  r_next.full = 1'b0;
               end
               else
                  r_next.beat = r_reg.beat + 3'h1;
            end
            else if (!r_reg.cclk && (r_reg.full || r_reg.st == H_TAIL))
            begin
               if (r_reg.div == 8'(HALF - 1))
               begin
                  r_next.cclk = 1'b1;
                  r_next.div  = '0;
               end
            end
            else if (!r_reg.cclk)
               r_next.div = '0;
            if (r_reg.st == H_LOAD && sync_q[1] && !r_reg.cclk)
            begin
               r_next.st    = H_TAIL;
               r_next.falls = '0;
               r_next.div   = '0;
            end
            if (!sync_q[2])
            begin
               // Device dropped ready: the load is lost
               r_next.st    = H_IDLE;
               r_next.doe   = 1'b0;
               r_next.cclk  = 1'b0;
               ev[E_FAULT]  = 1'b1;
            end
         end
         default:
         begin
            r_next.cclk = 1'b0;
         end
      endcase
      // New events win over a read clear in the same cycle
      r_next.istat = r_next.istat | ev;
      r_next.irq   = |(r_next.istat & r_next.mask);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         r_reg       <= '0;
         r_reg.st    <= H_IDLE;
         r_reg.req_n <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign prdata                = r_reg.prdata;
   assign pready                = r_reg.pready;
   assign pslverr               = r_reg.slverr;
   assign irq                   = r_reg.irq;
   assign link.config_request_n = r_reg.req_n;
   assign link.config_clock     = r_reg.cclk;
   assign link.data_host        = {16'h0000, r_reg.word};
   assign link.data_host_oe     = r_reg.doe;

endmodule : pcl_host
`default_nettype wire

// ---- design/pcl_pkg.sv ----
package pcl_pkg;

   // ----------------------------------------------------------------
   // Timing and widths
   // ----------------------------------------------------------------
   localparam int CLK_MHZ     = 40;                // System clock rate
   localparam int POR_US      = 100;               // Power-on hold time
   localparam int POR_CYC     = POR_US * CLK_MHZ;  // Power-on hold in clocks
   localparam int INIT_CYC    = 16;                // Initialisation length
   localparam int CCLK_HALF   = 4;                 // Host clock half period
   localparam int REQ_LOW_CYC = 8;                 // Host request pulse
   localparam int TAIL_FALLS  = 2;                 // Falling edges after done
   localparam int DATA_W      = 32;                // Data lines on the link
   localparam int WORD_W      = 16;                // Widest load word

   // ----------------------------------------------------------------
   // Controller register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_DATA   = 8'h08;
   localparam logic [7:0] A_ISTAT  = 8'h0C;
   localparam logic [7:0] A_IMASK  = 8'h10;
   localparam int C_START  = 0;
   localparam int C_WIDE   = 1;
   localparam int C_DECOMP = 2;
   localparam int C_SECURE = 3;
   localparam int E_READY  = 0;
   localparam int E_DONE   = 1;
   localparam int E_FAULT  = 2;
   localparam int N_EV     = 3;

   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      D_POR  = 3'h0, D_HOLD = 3'h1, D_LOAD = 3'h3,
      D_DONE = 3'h2, D_INIT = 3'h6, D_USER = 3'h7
   } pcl_dev_st_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_REQ = 3'h1, H_WAIT = 3'h3, H_LOAD = 3'h2, H_TAIL = 3'h6
   } pcl_host_st_t;

   // Clocks per word for the given bus width and features
   function automatic logic [2:0] pcl_ratio(input logic wide16,
                                            input logic decomp,
                                            input logic secure);
      if (decomp)
         return wide16 ? 3'h4 : 3'h2;
      else if (wide16 && secure)
         return 3'h2;
      else
         return 3'h1;
   endfunction : pcl_ratio

endpackage : pcl_pkg

// ---- design/pcl_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pcl_if;
   import pcl_pkg::*;
   logic                config_request_n;  // Host, push-pull
   logic                config_clock;      // Host, push-pull
   logic [DATA_W-1:0]   data_host;
   logic                data_host_oe;
   logic [DATA_W-1:0]   data_dev;
   logic                data_dev_oe;
   logic                ready_n_o;
   logic                ready_n_oe;
   logic                done_o;
   logic                done_oe;
   logic                init_o;
   logic                init_oe;
   // Resolved wire levels, open-drain lines pulled high
   logic [DATA_W-1:0]   data;
   logic                device_ready_n;
   logic                load_complete;
   logic                init_done;
   assign data = data_host_oe ? data_host : (data_dev_oe ? data_dev : '0);
   assign device_ready_n = ready_n_oe ? ready_n_o : 1'b1;
   assign load_complete  = done_oe ? done_o : 1'b1;
   assign init_done      = init_oe ? init_o : 1'b1;
   modport dev (input config_request_n, config_clock, data,
                output data_dev, data_dev_oe, ready_n_o, ready_n_oe,
                done_o, done_oe, init_o, init_oe);
   modport host (output config_request_n, config_clock, data_host, data_host_oe,
                 input device_ready_n, load_complete, init_done);
endinterface : pcl_if
`default_nettype wire

// ---- design/pcl_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcl_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed { logic [W-1:0] s1; logic [W-1:0] s2; } pcl_sync_t;
   pcl_sync_t s_reg, s_next;

   // First stage feeds only the second
   always_comb
   begin
      s_next.s1 = d;
      s_next.s2 = s_reg.s1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_reg <= '{s1: INIT, s2: INIT};
      else
         s_reg <= s_next;
   end

   assign q = s_reg.s2;
endmodule : pcl_sync
`default_nettype wire

// ---- design/pcl_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - 8-bit: 1 clock/word, 2 if decompressing
// - 16-bit: 1, 2 secure, 4 decompressing
// - Host drives bits 15..0 or 7..0
// - After load, data lines become user I/O
// - User mode: request, ready, complete high
// - Request low aborts, starts reconfiguration
// - Ready held low through power-on delay
// - Load complete low from power-up through load
// - Host sends the whole image
// - Load complete released after all words
// - Two falling edges then start initialisation
// - Clock ignored once initialisation starts, never floating
// - Init done held low only during initialisation
module pcl_device
   import pcl_pkg::*;
#(
   parameter int POR_CYCLES  = POR_CYC,
   parameter int IMAGE_WORDS = 1024,
   parameter int INIT_CYCLES = INIT_CYC
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   pcl_if.dev                     link,
   input  wire logic              wide16,
   input  wire logic              decompress,
   input  wire logic              secure,
   input  wire logic              init_done_en,
   input  wire logic [DATA_W-1:0] user_dout,
   input  wire logic              user_doe,
   output logic      [WORD_W-1:0] cfg_word,
   output logic                   cfg_valid,
   output logic                   user_mode,
   output logic                   loading
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      pcl_dev_st_t       st;
      logic [31:0]       cnt;
      logic [2:0]        beat;
      logic [1:0]        falls;
      logic              w16;
      logic              dec;
      logic              sec;
      logic              ide;
      logic              clk_q;
      logic              ready_oe;
      logic              done_oe;
      logic              init_oe;
      logic [DATA_W-1:0] dout;
      logic              doe;
      logic [WORD_W-1:0] word;
      logic              valid;
      logic              umode;
      logic              busy;
   } pcl_dev_t;

   pcl_dev_t r_reg, r_next;

   localparam int SYNC_W = WORD_W + 2;
   localparam logic [SYNC_W-1:0] SYNC_INIT = {1'b1, {(SYNC_W-1){1'b0}}};  // Request high, clock low

   logic [SYNC_W-1:0] sync_q;
   logic              req_n_s;
   logic              cclk_s;
   logic [WORD_W-1:0] data_s;
   logic              rise;
   logic              fall;
   logic [2:0]        ratio;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Data passes the same two stages as the clock so the two stay aligned
   pcl_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({link.config_request_n, link.config_clock, link.data[WORD_W-1:0]}),
      .q    (sync_q)
   );

   assign req_n_s = sync_q[SYNC_W-1];
   assign cclk_s  = sync_q[SYNC_W-2];
   assign data_s  = sync_q[WORD_W-1:0];
   assign rise    = cclk_s & ~r_reg.clk_q;
   assign fall    = ~cclk_s & r_reg.clk_q;
   assign ratio   = pcl_ratio(r_reg.w16, r_reg.dec, r_reg.sec);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      r_next       = r_reg;
      r_next.valid = 1'b0;
      r_next.clk_q = cclk_s;
      if (!req_n_s && r_reg.st != D_POR)
      begin
         // Reconfiguration request wins over any state but D_POR
         r_next.st       = D_HOLD;
         r_next.cnt      = '0;
         r_next.ready_oe = 1'b1;
         r_next.done_oe  = 1'b1;
         r_next.init_oe  = 1'b0;
         r_next.doe      = 1'b0;
         r_next.umode    = 1'b0;
         r_next.busy     = 1'b1;
      end
      else
      begin
         case (r_reg.st)
            D_POR:
            begin
               // Ready and complete both held low for the whole delay
               r_next.ready_oe = 1'b1;
               r_next.done_oe  = 1'b1;
               r_next.cnt      = r_reg.cnt + 32'h00000001;
               if (r_reg.cnt == 32'(POR_CYCLES - 1))
               begin
                  r_next.st  = D_HOLD;
                  r_next.cnt = '0;
               end
            end
            D_HOLD:
            begin
               // Mode straps are caught here, well after reset release
               r_next.w16 = wide16;
               r_next.dec = decompress;
               r_next.sec = secure;
               r_next.ide = init_done_en;
               if (req_n_s)
               begin
                  r_next.st       = D_LOAD;
                  r_next.ready_oe = 1'b0;
                  r_next.beat     = '0;
                  r_next.cnt      = '0;
               end
            end
            D_LOAD:
            begin
               // A word counts once it has been held for ratio rising edges;
               // the last sample is the one kept
               if (rise)
               begin
                  if (r_reg.beat == ratio - 3'h1)
                  begin
                     r_next.beat  = '0;
                     r_next.word  = r_reg.w16 ? data_s : {8'h00, data_s[7:0]};
                     r_next.valid = 1'b1;
                     r_next.cnt   = r_reg.cnt + 32'h00000001;
                     if (r_reg.cnt == 32'(IMAGE_WORDS - 1))
                     begin
                        // Complete goes high only after the final word
                        r_next.st      = D_DONE;
                        r_next.done_oe = 1'b0;
                        r_next.falls   = '0;
                     end
                  end
                  else
                  begin
                     r_next.beat = r_reg.beat + 3'h1;
                  end
               end
            end
            D_DONE:
            begin
               if (fall)
               begin
                  r_next.falls = r_reg.falls + 2'h1;
                  if (r_reg.falls == 2'(TAIL_FALLS - 1))
                  begin
                     r_next.st      = D_INIT;
                     r_next.cnt     = '0;
                     r_next.init_oe = r_reg.ide;
                  end
               end
            end
            D_INIT:
            begin
               r_next.cnt = r_reg.cnt + 32'h00000001;
               if (r_reg.cnt == 32'(INIT_CYCLES - 1))
               begin
                  r_next.st      = D_USER;
                  r_next.init_oe = 1'b0;
                  r_next.umode   = 1'b1;
                  r_next.busy    = 1'b0;
               end
            end
            D_USER:
            begin
               // Link clock has no effect here; lines now belong to the user
               r_next.ready_oe = 1'b0;
               r_next.done_oe  = 1'b0;
               r_next.dout     = user_dout;
               r_next.doe      = user_doe;
            end
            default:
            begin
               r_next.st = D_POR;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         r_reg          <= '0;
         r_reg.st       <= D_POR;
         r_reg.ready_oe <= 1'b1;
         r_reg.done_oe  <= 1'b1;
         r_reg.busy     <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open-drain lines only ever pull low
   assign link.ready_n_o   = 1'b0;
   assign link.ready_n_oe  = r_reg.ready_oe;
   assign link.done_o      = 1'b0;
   assign link.done_oe     = r_reg.done_oe;
   assign link.init_o      = 1'b0;
   assign link.init_oe     = r_reg.init_oe;
   assign link.data_dev    = r_reg.dout;
   assign link.data_dev_oe = r_reg.doe;
   assign cfg_word         = r_reg.word;
   assign cfg_valid        = r_reg.valid;
   assign user_mode        = r_reg.umode;
   assign loading          = r_reg.busy;

endmodule : pcl_device
`default_nettype wire

// ---- test/pcl_link_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcl_link_asserts
   import pcl_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              config_request_n,
   input wire logic              config_clock,
   input wire logic [DATA_W-1:0] data,
   input wire logic              data_host_oe,
   input wire logic              data_dev_oe,
   input wire logic              device_ready_n,
   input wire logic              load_complete
);
   // ------------------
   // Link checks
   // ------------------
   logic [3:0] falls_reg;
   // Clock falls since complete rose; saturates so it cannot wrap
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         falls_reg <= 4'h0;
      else if (!load_complete)
         falls_reg <= 4'h0;
      else if ($fell(config_clock) && falls_reg != 4'hF)
         falls_reg <= falls_reg + 4'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_por; $rose(rstn) |-> (!device_ready_n && !load_complete) [*8]; endproperty
   a_por: assert property (p_por) else $error("early release");
   property p_keep; $fell(load_complete) |-> !config_request_n; endproperty
   a_keep: assert property (p_keep) else $error("complete dropped");
   property p_abort; $fell(config_request_n) |-> ##[1:8] !load_complete; endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_uio; data_dev_oe |-> load_complete; endproperty
   a_uio: assert property (p_uio) else $error("early user drive");
   property p_tail; $rose(load_complete) |-> ##[1:60] falls_reg == 4'h2 [*4]; endproperty
   a_tail: assert property (p_tail) else $error("tail edges");
   property p_hold; $rose(config_clock) && data_host_oe |-> $stable(data) [*4]; endproperty
   a_hold: assert property (p_hold) else $error("word moved");
   property p_wait; $rose(data_host_oe) |-> device_ready_n; endproperty
   a_wait: assert property (p_wait) else $error("data too early");
   property p_upper; data_host_oe |-> data[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper lines driven");
   c_done: cover property ($rose(load_complete));
   c_abort: cover property ($fell(config_request_n) ##[1:8] $fell(load_complete));
   c_uio: cover property ($rose(data_dev_oe));
endmodule : pcl_link_asserts
`default_nettype wire

// ---- test/parallel_config_loader_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module parallel_config_loader_tb_top;
   import pcl_pkg::*;
   logic              clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic              w16 = 1'b0, dcm = 1'b0, sec = 1'b0, user_doe = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, user_dout = 32'h0, prdata, rd;
   logic              pready, pslverr, irq, cfg_valid, user_mode, loading;
   logic [WORD_W-1:0] cfg_word;
   logic [15:0]       wq[$];
   int                tq[$];
   int                n_fail = 0, n_checks = 0, cyc = 0, n_lo = 0;
   pcl_if i_pcl_if ();
   pcl_device #(.POR_CYCLES(20), .IMAGE_WORDS(4)) i_pcl_device (.clk, .rstn,
      .link(i_pcl_if), .wide16(w16), .decompress(dcm), .secure(sec), .init_done_en(1'b1),
      .user_dout, .user_doe, .cfg_word, .cfg_valid, .user_mode, .loading);
   pcl_host i_pcl_host (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .link(i_pcl_if));
   pcl_link_asserts i_pcl_link_asserts (.clk, .rstn,
      .config_request_n(i_pcl_if.config_request_n), .config_clock(i_pcl_if.config_clock),
      .data(i_pcl_if.data), .data_host_oe(i_pcl_if.data_host_oe),
      .data_dev_oe(i_pcl_if.data_dev_oe), .device_ready_n(i_pcl_if.device_ready_n),
      .load_complete(i_pcl_if.load_complete));
   always #12.5 clk = ~clk;
   // ------------------
   // Helpers
   // ------------------
   // Word capture with arrival cycle, so spacing can be judged; init low cycles
   always @(posedge clk)
   begin
      cyc++;
      if (i_pcl_if.init_done === 1'b0)
         n_lo++;
      if (cfg_valid === 1'b1)
      begin
         wq.push_back(cfg_word);
         tq.push_back(cyc);
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   // One APB transfer; a hung slave is cut off and counted
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1 && ++n < 4000);
      chk(pready, 1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // ------------------
   // Scenarios
   // ------------------
   task automatic t_por();
      chk({loading, i_pcl_if.device_ready_n, i_pcl_if.load_complete}, 3'h4);
      apb(0, 8'h14, 32'h0);
      chk(pslverr, 1);
      repeat (30) @(posedge clk);
      chk(i_pcl_if.device_ready_n, 1);
   endtask : t_por
   // Full load in mode i, then user-mode levels, pins and interrupt
   task automatic t_load(input int i);
      logic [15:0] d;
      int          rt, n;
      rt = i[1] ? (i[0] ? 4 : 2) : ((i[0] && i[2]) ? 2 : 1);
      w16 <= i[0];
      dcm <= i[1];
      sec <= i[2];
      wq.delete();
      tq.delete();
      n_lo = 0;
      apb(1, A_IMASK, {30'h0, i != 0, 1'b0});
      apb(1, A_CTRL, {28'h0, i[2:0], 1'b1});
      for (int k = 0; k < 4; k++)
         apb(1, A_DATA, {16'h5A5A, 16'hC3A5 ^ (16'(k) * 16'h0111)});
      n = 0;
      while (user_mode !== 1'b1 && n++ < 3000)
         @(posedge clk);
      chk(wq.size(), 4);
      for (int k = 0; k < wq.size(); k++)
      begin
         d = 16'hC3A5 ^ (16'(k) * 16'h0111);
         chk(wq[k], i[0] ? d : {8'h00, d[7:0]});
         // Refilling the word slot costs the host one clock per word
         if (k > 0)
            chk(tq[k] - tq[k-1], rt * 2 * CCLK_HALF + 1);
      end
      chk(user_mode, 1);
      chk({i_pcl_if.config_request_n, i_pcl_if.device_ready_n, i_pcl_if.load_complete}, 3'h7);
      chk(i_pcl_if.init_done, 1);
      chk(n_lo, INIT_CYC);
      chk(irq, i != 0);
      apb(0, A_ISTAT, 32'h0);
      chk(rd[1], 1);
      user_dout <= 32'hC0DE0000 | 32'(i);
      user_doe  <= 1'b1;
      repeat (3) @(posedge clk);
      chk(i_pcl_if.data, 32'hC0DE0000 | 32'(i));
      chk(irq, 0);
      user_doe <= 1'b0;
   endtask : t_load
   // Reset, power-on, then every mode, each load after the first aborting user mode
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_por();
      for (int i = 0; i < 8; i++)
         t_load(i);
      stop_test();
   end
   // Watchdog, far beyond eight loads
   initial
   begin
      #1ms;
      n_fail++;
      stop_test();
   end
endmodule : parallel_config_loader_tb_top
`default_nettype wire
